// >>> sdp_regs.svh
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH
// ==========================================================
// Register map, byte offsets on the bus.
`define SDP_OFF_INSTR 12'h000
`define SDP_OFF_STATUS 12'h004
`define SDP_OFF_CORE_CTRL 12'h008
`define SDP_OFF_IRQ_STAT 12'h00c
`define SDP_OFF_IRQ_MASK 12'h010
`define SDP_OFF_ACCUM_A_LO 12'h014
`define SDP_OFF_ACCUM_A_HI 12'h018
`define SDP_OFF_ACCUM_B_LO 12'h01c
`define SDP_OFF_ACCUM_B_HI 12'h020
`define SDP_OFF_DEFAULT_WORK_REG_BASE 12'h040
`define SDP_OFF_RAM_BASE 12'h800
// ==========================================================
// Status register fields.
`define SDP_SR_C 0
`define SDP_SR_Z 1
`define SDP_SR_OV 2
`define SDP_SR_N 3
`define SDP_SR_DC 8
`define SDP_SR_SAB 10
`define SDP_SR_OAB 11
`define SDP_SR_SB 12
`define SDP_SR_SA 13
`define SDP_SR_OB 14
`define SDP_SR_OA 15
// ==========================================================
// Core control fields.
`define SDP_CC_ACCSAT 4
`define SDP_CC_ACC_B_CLAMP_ENABLE 6
`define SDP_CC_SATA 7
// ==========================================================
// Interrupt status fields.
`define SDP_IRQ_DONE 0
`define SDP_IRQ_WRAP 1
`define SDP_IRQ_ACCOVF 2
`define SDP_IRQ_CLAMP 3
`define SDP_IRQ_ILLEGAL 4
// ==========================================================
// Reset values.
`define SDP_RST_SR 16'h0000
`define SDP_RST_CC 16'h0000
`define SDP_RST_IRQ 5'h00
`endif

// >>> sdp_pkg.sv
package sdp_pkg;
  typedef enum {SDP_IDLE, SDP_EXEC} sdp_state_type;
  typedef enum logic [2:0] {
    SDP_K_TRI = 3'h0,
    SDP_K_FILE = 3'h1,
    SDP_K_LIT = 3'h2,
    SDP_K_ACC = 3'h3,
    SDP_K_BAD = 3'h4
  } sdp_kind_type;
  typedef enum logic [2:0] {
    SDP_AM_DIRECT = 3'h0,
    SDP_AM_IND = 3'h1,
    SDP_AM_POSTINC = 3'h2,
    SDP_AM_POSTDEC = 3'h3,
    SDP_AM_PREINC = 3'h4,
    SDP_AM_PREDEC = 3'h5
  } sdp_amode_type;
endpackage : sdp_pkg

// >>> sdp_top.sv
// Function
// - Three-operand base minus source into destination, indirect with pointer updates.
// - Width bit: zero selects word operation, one selects byte operation.
// - Integer forms update digit carry, negative, overflow, zero and carry.
// - With-borrow forms also subtract the inverse of the carry flag.
// - File form subtracts default working register and borrow from file register.
// - Destination bit picks default working register or the file register.
// - Default working register is working register zero.
// - With-borrow forms may clear zero flag but never set it.
// - Literal form subtracts unsigned ten-bit literal and borrow from register.
// - Literal form writes back into its own working register, direct only.
// - Literal and register number come from their own encoding fields.
// - Accumulator form: A minus B into A, else B minus A into B.
// - Accumulator form updates accumulator overflow and clamp flags only.
// - File address comes from its dedicated field of the instruction.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "sdp_regs.svh"
module sdp_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic IRQ_O
);
  // ==========================================================
  // Storage.
  logic [15:0] w_reg [16];
  logic [15:0] ram [256];
  logic [23:0] instr_reg;
  logic [15:0] sr_reg;
  logic [15:0] cc_reg;
  logic [39:0] accum_a_reg;
  logic [39:0] accum_b_reg;
  logic [4:0] irq_stat_reg;
  logic [4:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  sdp_pkg::sdp_state_type state_reg;

  function automatic logic [15:0] sdp_merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] sel);
    sdp_merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : sdp_merge

  // ==========================================================
  // Wishbone slave: one wait state, writes land on the ack edge.
  logic req;
  logic bus_wr;
  logic [11:0] adr;
  logic hit_w;
  logic hit_ram;
  assign req = WB_CYC_I & WB_STB_I;
  assign bus_wr = req & WB_WE_I & ack_reg;
  assign adr = {WB_ADR_I, 2'b00};
  assign hit_w = adr[11:6] == 6'(`SDP_OFF_DEFAULT_WORK_REG_BASE >> 6);
  assign hit_ram = adr[11:10] == 2'(`SDP_OFF_RAM_BASE >> 10);
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
  assign IRQ_O = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_w) begin
      rd_mux = {16'h0000, w_reg[adr[5:2]]};
    end else if (hit_ram) begin
      rd_mux = {16'h0000, ram[adr[9:2]]};
    end else begin
      unique case (adr)
        `SDP_OFF_INSTR: rd_mux = {8'h00, instr_reg};
        `SDP_OFF_STATUS: rd_mux = {16'h0000, sr_reg};
        `SDP_OFF_CORE_CTRL: rd_mux = {16'h0000, cc_reg};
        `SDP_OFF_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_reg};
        `SDP_OFF_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_reg};
        `SDP_OFF_ACCUM_A_LO: rd_mux = accum_a_reg[31:0];
        `SDP_OFF_ACCUM_A_HI: rd_mux = {24'h000000, accum_a_reg[39:32]};
        `SDP_OFF_ACCUM_B_LO: rd_mux = accum_b_reg[31:0];
        `SDP_OFF_ACCUM_B_HI: rd_mux = {24'h000000, accum_b_reg[39:32]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dat_reg <= 32'h0000_0000;
    end else if (req & ~ack_reg) begin
      dat_reg <= rd_mux;
    end
  end

  // ==========================================================
  // Sequencer: a write to the instruction register runs it on the next edge.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      instr_reg <= 24'h000000;
      state_reg <= sdp_pkg::SDP_IDLE;
    end else begin
      state_reg <= sdp_pkg::SDP_IDLE;
      if (bus_wr && adr == `SDP_OFF_INSTR) begin
        instr_reg <= {WB_SEL_I[2] ? WB_DAT_I[23:16] : instr_reg[23:16],
                      sdp_merge(instr_reg[15:0], WB_DAT_I[15:0], WB_SEL_I[1:0])};
        state_reg <= sdp_pkg::SDP_EXEC;
      end
    end
  end

  // ==========================================================
  // Decode and integer datapath.
  sdp_pkg::sdp_kind_type kind;
  logic exec;
  logic byte_op;
  logic borrow_form;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [15:0] src_ptr;
  logic [15:0] dst_ptr;
  logic [15:0] src_ea;
  logic [15:0] dst_ea;
  logic [15:0] step;
  logic [2:0] smode;
  logic [2:0] dmode;
  logic [3:0] wb_idx;
  logic [3:0] ws_idx;
  logic [3:0] wd_idx;
  logic [12:0] faddr;
  logic cin;
  logic [8:0] sum8;
  logic [16:0] sum16;
  logic [4:0] sum4;
  logic [15:0] res;
  logic c_out;
  logic dc_out;
  logic n_out;
  logic ov_out;
  logic z_out;
  logic msb_a;
  logic msb_b;

  assign exec = state_reg == sdp_pkg::SDP_EXEC;
  assign byte_op = instr_reg[14];
  assign wb_idx = instr_reg[18:15];
  assign smode = instr_reg[6:4];
  assign ws_idx = instr_reg[3:0];
  assign dmode = instr_reg[13:11];
  assign wd_idx = instr_reg[10:7];
  assign faddr = instr_reg[12:0];
  assign step = byte_op ? 16'h0001 : 16'h0002;
  assign src_ptr = w_reg[ws_idx];
  assign dst_ptr = w_reg[wd_idx];

  // Pre-modifying modes address with the updated pointer, the rest with the old one.
  function automatic logic [15:0] sdp_ea(input logic [2:0] m, input logic [15:0] p, input logic [15:0] s);
    sdp_ea = m == sdp_pkg::SDP_AM_PREINC ? p + s : (m == sdp_pkg::SDP_AM_PREDEC ? p - s : p);
  endfunction : sdp_ea

  function automatic logic [15:0] sdp_ptr_next(input logic [2:0] m, input logic [15:0] p, input logic [15:0] s);
    if (m == sdp_pkg::SDP_AM_POSTINC || m == sdp_pkg::SDP_AM_PREINC) begin
      sdp_ptr_next = p + s;
    end else if (m == sdp_pkg::SDP_AM_POSTDEC || m == sdp_pkg::SDP_AM_PREDEC) begin
      sdp_ptr_next = p - s;
    end else begin
      sdp_ptr_next = p;
    end
  endfunction : sdp_ptr_next

  function automatic logic [15:0] sdp_lane(input logic [15:0] word, input logic lane);
    sdp_lane = lane ? {8'h00, word[15:8]} : word;
  endfunction : sdp_lane

  assign src_ea = sdp_ea(smode, src_ptr, step);
  assign dst_ea = sdp_ea(dmode, dst_ptr, step);

  always_comb begin
    kind = sdp_pkg::SDP_K_BAD;
    if (instr_reg[23:19] == 5'h0a && smode <= 3'h5 && dmode <= 3'h5) begin
      kind = sdp_pkg::SDP_K_TRI;
    end else if (instr_reg[23:16] == 8'hb5) begin
      kind = sdp_pkg::SDP_K_FILE;
    end else if (instr_reg[23:16] == 8'hb1) begin
      kind = sdp_pkg::SDP_K_LIT;
    end else if (instr_reg[23:16] == 8'hcb && instr_reg[14:0] == 15'h3000) begin
      kind = sdp_pkg::SDP_K_ACC;
    end
  end

  always_comb begin
    borrow_form = 1'b0;
    op_a = 16'h0000;
    op_b = 16'h0000;
    unique case (kind)
      sdp_pkg::SDP_K_TRI: begin
        op_a = w_reg[wb_idx];
        op_b = smode == sdp_pkg::SDP_AM_DIRECT ? src_ptr
               : sdp_lane(ram[src_ea[8:1]], byte_op & src_ea[0]);
      end
      sdp_pkg::SDP_K_FILE: begin
        borrow_form = instr_reg[15];
        op_a = sdp_lane(ram[faddr[8:1]], byte_op & faddr[0]);
        op_b = w_reg[0];
      end
      sdp_pkg::SDP_K_LIT: begin
        borrow_form = instr_reg[15];
        op_a = w_reg[ws_idx];
        op_b = {6'h00, instr_reg[13:4]};
      end
      default: begin
        op_a = 16'h0000;
      end
    endcase
  end

  // Subtraction as a plus not-b plus carry-in; the carry-in is the inverse borrow.
  assign cin = borrow_form ? sr_reg[`SDP_SR_C] : 1'b1;
  assign sum4 = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, cin};
  assign sum8 = {1'b0, op_a[7:0]} + {1'b0, ~op_b[7:0]} + {8'h00, cin};
  assign sum16 = {1'b0, op_a} + {1'b0, ~op_b} + {16'h0000, cin};
  assign res = byte_op ? {8'h00, sum8[7:0]} : sum16[15:0];
  assign msb_a = byte_op ? op_a[7] : op_a[15];
  assign msb_b = byte_op ? op_b[7] : op_b[15];
  assign n_out = byte_op ? res[7] : res[15];
  assign c_out = byte_op ? sum8[8] : sum16[16];
  assign dc_out = byte_op ? sum4[4] : sum8[8];
  assign ov_out = (msb_a != msb_b) && (n_out != msb_a);
  // A multi-precision chain keeps zero only if every word was zero.
  assign z_out = (byte_op ? res[7:0] == 8'h00 : res == 16'h0000)
                 && (~borrow_form || sr_reg[`SDP_SR_Z]);

  function automatic logic [15:0] sdp_put(input logic [15:0] old, input logic [15:0] r, input logic bop,
                                          input logic lane);
    sdp_put = ~bop ? r : (lane ? {r[7:0], old[7:0]} : {old[15:8], r[7:0]});
  endfunction : sdp_put

  // ==========================================================
  // Accumulator datapath.
  logic sel_a;
  logic [40:0] acc_diff;
  logic clamp_en;
  logic ovf40;
  logic ovf_lim;
  logic [39:0] acc_res;
  logic acc_ov;
  assign sel_a = ~instr_reg[15];
  assign acc_diff = sel_a ? {accum_a_reg[39], accum_a_reg} - {accum_b_reg[39], accum_b_reg}
                          : {accum_b_reg[39], accum_b_reg} - {accum_a_reg[39], accum_a_reg};
  assign clamp_en = sel_a ? cc_reg[`SDP_CC_SATA] : cc_reg[`SDP_CC_ACC_B_CLAMP_ENABLE];
  assign ovf40 = acc_diff[40] != acc_diff[39];
  assign ovf_lim = cc_reg[`SDP_CC_ACCSAT] ? ovf40 : ~(&acc_diff[40:31] | ~|acc_diff[40:31]);

  // Clamp limits follow the accumulator mode: 9.31 uses all 40 bits, 1.31 only 32.
  always_comb begin
    acc_res = acc_diff[39:0];
    if (clamp_en && ovf_lim) begin
      if (cc_reg[`SDP_CC_ACCSAT]) begin
        acc_res = acc_diff[40] ? 40'h80_0000_0000 : 40'h7f_ffff_ffff;
      end else begin
        acc_res = acc_diff[40] ? 40'hff_8000_0000 : 40'h00_7fff_ffff;
      end
    end
  end
  assign acc_ov = ~(&acc_res[39:31] | ~|acc_res[39:31]);

  // ==========================================================
  // Working registers.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 16; i++) begin
        w_reg[i] <= 16'h0000;
      end
    end else begin
      if (bus_wr && hit_w) begin
        w_reg[adr[5:2]] <= sdp_merge(w_reg[adr[5:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
      end
      if (exec && kind == sdp_pkg::SDP_K_TRI) begin
        w_reg[ws_idx] <= sdp_ptr_next(smode, src_ptr, step);
        w_reg[wd_idx] <= sdp_ptr_next(dmode, dst_ptr, step);
        if (dmode == sdp_pkg::SDP_AM_DIRECT) begin
          w_reg[wd_idx] <= sdp_put(dst_ptr, res, byte_op, 1'b0);
        end
      end
      if (exec && kind == sdp_pkg::SDP_K_FILE && ~instr_reg[13]) begin
        w_reg[0] <= sdp_put(w_reg[0], res, byte_op, 1'b0);
      end
      if (exec && kind == sdp_pkg::SDP_K_LIT) begin
        w_reg[ws_idx] <= sdp_put(w_reg[ws_idx], res, byte_op, 1'b0);
      end
    end
  end

  // ==========================================================
  // Data memory, no reset so that it maps onto plain RAM.
  always_ff @(posedge REF_CLK) begin
    if (bus_wr && hit_ram) begin
      ram[adr[9:2]] <= sdp_merge(ram[adr[9:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
    end
    if (exec && kind == sdp_pkg::SDP_K_TRI && dmode != sdp_pkg::SDP_AM_DIRECT) begin
      ram[dst_ea[8:1]] <= sdp_put(ram[dst_ea[8:1]], res, byte_op, dst_ea[0]);
    end
    if (exec && kind == sdp_pkg::SDP_K_FILE && instr_reg[13]) begin
      ram[faddr[8:1]] <= sdp_put(ram[faddr[8:1]], res, byte_op, faddr[0]);
    end
  end

  // ==========================================================
  // Accumulators.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      accum_a_reg <= 40'h00_0000_0000;
      accum_b_reg <= 40'h00_0000_0000;
    end else if (exec && kind == sdp_pkg::SDP_K_ACC) begin
      if (sel_a) begin
        accum_a_reg <= acc_res;
      end else begin
        accum_b_reg <= acc_res;
      end
    end else if (bus_wr) begin
      if (adr == `SDP_OFF_ACCUM_A_LO) accum_a_reg[31:0] <= WB_DAT_I;
      if (adr == `SDP_OFF_ACCUM_A_HI) accum_a_reg[39:32] <= WB_DAT_I[7:0];
      if (adr == `SDP_OFF_ACCUM_B_LO) accum_b_reg[31:0] <= WB_DAT_I;
      if (adr == `SDP_OFF_ACCUM_B_HI) accum_b_reg[39:32] <= WB_DAT_I[7:0];
    end
  end

  // ==========================================================
  // Status and core control.
  logic [15:0] sr_next;
  always_comb begin
    sr_next = sr_reg;
    if (bus_wr && adr == `SDP_OFF_STATUS) begin
      sr_next = sdp_merge(sr_reg, WB_DAT_I[15:0], WB_SEL_I[1:0]);
    end
    if (exec && (kind == sdp_pkg::SDP_K_TRI || kind == sdp_pkg::SDP_K_FILE || kind == sdp_pkg::SDP_K_LIT)) begin
      sr_next[`SDP_SR_C] = c_out;
      sr_next[`SDP_SR_Z] = z_out;
      sr_next[`SDP_SR_OV] = ov_out;
      sr_next[`SDP_SR_N] = n_out;
      sr_next[`SDP_SR_DC] = dc_out;
    end
    if (exec && kind == sdp_pkg::SDP_K_ACC) begin
      // The clamp flags stay set until software clears them.
      if (sel_a) begin
        sr_next[`SDP_SR_OA] = acc_ov;
        sr_next[`SDP_SR_SA] = sr_reg[`SDP_SR_SA] | ovf40 | (clamp_en & ovf_lim);
      end else begin
        sr_next[`SDP_SR_OB] = acc_ov;
        sr_next[`SDP_SR_SB] = sr_reg[`SDP_SR_SB] | ovf40 | (clamp_en & ovf_lim);
      end
    end
    sr_next[`SDP_SR_OAB] = sr_next[`SDP_SR_OA] | sr_next[`SDP_SR_OB];
    sr_next[`SDP_SR_SAB] = sr_next[`SDP_SR_SA] | sr_next[`SDP_SR_SB];
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sr_reg <= `SDP_RST_SR;
    end else begin
      sr_reg <= sr_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cc_reg <= `SDP_RST_CC;
    end else if (bus_wr && adr == `SDP_OFF_CORE_CTRL) begin
      cc_reg <= sdp_merge(cc_reg, WB_DAT_I[15:0], WB_SEL_I[1:0]);
    end
  end

  // ==========================================================
  // Interrupts: sticky events, write one to clear, a new event wins.
  logic [4:0] irq_ev;
  always_comb begin
    irq_ev = 5'h00;
    irq_ev[`SDP_IRQ_DONE] = exec;
    irq_ev[`SDP_IRQ_WRAP] = exec && kind != sdp_pkg::SDP_K_ACC && kind != sdp_pkg::SDP_K_BAD && ov_out;
    irq_ev[`SDP_IRQ_ACCOVF] = exec && kind == sdp_pkg::SDP_K_ACC && (acc_ov || ovf40);
    irq_ev[`SDP_IRQ_CLAMP] = exec && kind == sdp_pkg::SDP_K_ACC && clamp_en && ovf_lim;
    irq_ev[`SDP_IRQ_ILLEGAL] = exec && kind == sdp_pkg::SDP_K_BAD;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      irq_stat_reg <= `SDP_RST_IRQ;
      irq_mask_reg <= `SDP_RST_IRQ;
    end else begin
      if (bus_wr && adr == `SDP_OFF_IRQ_STAT && WB_SEL_I[0]) begin
        irq_stat_reg <= (irq_stat_reg & ~WB_DAT_I[4:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      if (bus_wr && adr == `SDP_OFF_IRQ_MASK && WB_SEL_I[0]) begin
        irq_mask_reg <= WB_DAT_I[4:0];
      end
    end
  end
endmodule : sdp_top
`default_nettype wire

// >>> sdp_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sdp_top_asserts (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [11:2] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic IRQ_O
);
  // ==========================================================
  // Address classes of a pending read.
  logic req;
  logic rd_req;
  logic unmapped;
  logic half_reg;
  logic acc_hi;
  assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign rd_req = req && !WB_WE_I;
  assign unmapped = (WB_ADR_I >= 10'h009 && WB_ADR_I <= 10'h00f) || (WB_ADR_I >= 10'h020 && WB_ADR_I <= 10'h1ff)
    || (WB_ADR_I >= 10'h300);
  assign half_reg = (WB_ADR_I >= 10'h001 && WB_ADR_I <= 10'h004) || (WB_ADR_I >= 10'h010 && WB_ADR_I <= 10'h01f);
  assign acc_hi = (WB_ADR_I == 10'h006) || (WB_ADR_I == 10'h008);
  // ==========================================================
  // Bus handshake.
  ack_one_cycle_a: assert property (@(posedge REF_CLK) disable iff (RST) WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (@(posedge REF_CLK) disable iff (RST) req |=> WB_ACK_O)
    else $error("ack not given one cycle after request");
  ack_cause_a: assert property (@(posedge REF_CLK) disable iff (RST) WB_ACK_O |-> $past(req) && WB_CYC_I)
    else $error("ack without a request");
  reset_quiet_a: assert property (@(posedge REF_CLK) disable iff (1'b0)
    RST |=> !WB_ACK_O && WB_DAT_O == 32'h0 && !IRQ_O)
    else $error("outputs not quiet after reset");
  data_hold_a: assert property (@(posedge REF_CLK) disable iff (RST) (!WB_ACK_O && !req) |=> $stable(WB_DAT_O))
    else $error("read data moved without a request");
  // ==========================================================
  // Read data layout.
  unmapped_zero_a: assert property (@(posedge REF_CLK) disable iff (RST) (rd_req && unmapped) |=> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  half_upper_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (rd_req && half_reg) |=> WB_DAT_O[31:16] == 16'h0)
    else $error("upper half of a 16-bit register not zero");
  acc_hi_upper_a: assert property (@(posedge REF_CLK) disable iff (RST)
    (rd_req && acc_hi) |=> WB_DAT_O[31:8] == 24'h0)
    else $error("accumulator upper word wider than 8 bits");
  // The interrupt level can only move after a register write or an execution edge.
  irq_timing_a: assert property (@(posedge REF_CLK) disable iff (RST)
    $changed(IRQ_O) |-> $past(WB_ACK_O) || $past(WB_ACK_O, 2))
    else $error("interrupt moved outside a write or execution");
endmodule : sdp_top_asserts
bind sdp_top sdp_top_asserts sdp_top_asserts_i (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .IRQ_O(IRQ_O));
`default_nettype wire

// >>> sdp_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sdp_top_bench;
  logic REF_CLK = 1'b0;
  logic RST = 1'b1;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [11:2] WB_ADR_I = 10'h000;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  logic IRQ_O;
  logic [31:0] q;
  int n_errors = 0;
  int n_tests = 0;
  always #10 REF_CLK = ~REF_CLK;
  sdp_top sdp_top_i (.REF_CLK(REF_CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .IRQ_O(IRQ_O));
  // ==========================================================
  // Verdict.
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Classic Wishbone cycle; the bus is left idle for one cycle afterwards.
  task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d);
    int k;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a[11:2];
    WB_SEL_I <= 4'hf;
    WB_DAT_I <= d;
    k = 0;
    do begin
      @(posedge REF_CLK);
      k++;
    end while (WB_ACK_O !== 1'b1 && k < 20);
    if (WB_ACK_O !== 1'b1) begin
      $display("mismatch at %0t: no acknowledge", $time);
      n_errors++;
      results();
    end
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
    @(posedge REF_CLK);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic ex(input logic [23:0] i);
    bus(1'b1, 12'h000, {8'h00, i});
  endtask : ex
  task automatic chk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    n_tests++;
    if (q !== e) begin
      $display("mismatch at %0t: addr %h got %h expected %h", $time, a, q, e);
      n_errors++;
    end
  endtask : chk
  task automatic chki(input logic e);
    n_tests++;
    if (IRQ_O !== e) begin
      $display("mismatch at %0t: interrupt line %b expected %b", $time, IRQ_O, e);
      n_errors++;
    end
  endtask : chki
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    chk(12'h004, 32'h0);
    chk(12'h008, 32'h0);
    chk(12'h00c, 32'h0);
    chk(12'h010, 32'h0);
    chk(12'h014, 32'h0);
    chk(12'h024, 32'h0);
    wr(12'h024, 32'h1234);
    wr(12'h400, 32'h5678);
    chk(12'h024, 32'h0);
    chk(12'h400, 32'h0);
    // Word subtract through post-incremented pointers, interrupts masked.
    wr(12'h05c, 32'h2450);
    wr(12'h060, 32'h1808);
    wr(12'h064, 32'h2020);
    wr(12'h810, 32'h92e4);
    wr(12'h840, 32'ha557);
    ex(24'h5394a8);
    chk(12'h840, 32'h916c);
    chk(12'h060, 32'h180a);
    chk(12'h064, 32'h2022);
    chk(12'h004, 32'h000c);
    chk(12'h00c, 32'h03);
    chki(1'b0);
    wr(12'h010, 32'h02);
    chki(1'b1);
    wr(12'h00c, 32'h03);
    chki(1'b0);
    chk(12'h00c, 32'h0);
    wr(12'h010, 32'h1f);
    // Byte subtract keeps the upper byte of the destination.
    wr(12'h040, 32'h1732);
    wr(12'h044, 32'h7844);
    ex(24'h504001);
    chk(12'h040, 32'h17ee);
    chk(12'h004, 32'h0008);
    chki(1'b1);
    wr(12'h00c, 32'h1f);
    // Pre-decremented source, indirect destination whose pointer is kept.
    wr(12'h044, 32'h0500);
    wr(12'h048, 32'h0012);
    wr(12'h04c, 32'h0024);
    wr(12'h820, 32'h0100);
    ex(24'h5089d2);
    chk(12'h848, 32'h0400);
    chk(12'h048, 32'h0010);
    chk(12'h04c, 32'h0024);
    chk(12'h004, 32'h0101);
    // File register minus working register zero and borrow, high byte lane.
    wr(12'h004, 32'h0);
    wr(12'h040, 32'h7804);
    wr(12'hbfc, 32'h9439);
    ex(24'hb5ffff);
    chk(12'hbfc, 32'h8f39);
    chk(12'h004, 32'h0009);
    chk(12'h040, 32'h7804);
    // Zero result does not set the zero flag; result goes to working register zero.
    wr(12'h004, 32'h0);
    wr(12'h040, 32'h6234);
    wr(12'h808, 32'h6235);
    ex(24'hb58a04);
    chk(12'h040, 32'h0);
    chk(12'h808, 32'h6235);
    chk(12'h004, 32'h0101);
    // Literal forms, byte then word with the zero flag cleared.
    wr(12'h040, 32'h7804);
    wr(12'h004, 32'h0);
    ex(24'hb1c230);
    chk(12'h040, 32'h78e0);
    chk(12'h004, 32'h0108);
    wr(12'h050, 32'h6234);
    wr(12'h004, 32'h0003);
    ex(24'hb19084);
    chk(12'h050, 32'h612c);
    chk(12'h004, 32'h0101);
    chk(12'h040, 32'h78e0);
    // Plain file form: the zero flag follows the result.
    wr(12'h040, 32'h6235);
    ex(24'hb50a04);
    chk(12'h040, 32'h0);
    chk(12'h004, 32'h0103);
    // Accumulator A minus B, no clamping.
    wr(12'h004, 32'h0);
    wr(12'h014, 32'h120f098a);
    wr(12'h018, 32'h76);
    wr(12'h01c, 32'hf312bc17);
    wr(12'h020, 32'h23);
    ex(24'hcb3000);
    chk(12'h014, 32'h1efc4d73);
    chk(12'h018, 32'h52);
    chk(12'h004, 32'h8800);
    // Accumulator B minus A with clamping of B to the 32-bit limit.
    wr(12'h00c, 32'h1f);
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h40);
    wr(12'h014, 32'h90222ee1);
    wr(12'h018, 32'hff);
    wr(12'h01c, 32'h24568fe2);
    wr(12'h020, 32'h00);
    ex(24'hcbb000);
    chk(12'h01c, 32'h7fffffff);
    chk(12'h020, 32'h00);
    chk(12'h004, 32'h1400);
    chk(12'h00c, 32'h09);
    // An unknown encoding raises the illegal bit beside the done bit.
    wr(12'h00c, 32'h1f);
    ex(24'h000000);
    chk(12'h00c, 32'h11);
    chk(12'h004, 32'h1400);
    chki(1'b1);
    results();
  end
endmodule : sdp_top_bench
`default_nettype wire
